// File: inc/fpxu_pkg.sv
package fpxu_pkg;

  // ****************************************************************
  // operation codes from the datapath
  // ****************************************************************
  typedef enum logic [3:0] {
    FPXU_OP_NONE = 4'h0,
    FPXU_OP_ADD = 4'h1,
    FPXU_OP_SUB = 4'h2,
    FPXU_OP_MUL = 4'h3,
    FPXU_OP_DIV = 4'h4,
    FPXU_OP_PARTIAL_REMAINDER = 4'h5,
    FPXU_OP_SQUARE_ROOT = 4'h6,
    FPXU_OP_COMPARE = 4'h7,
    FPXU_OP_ZERO_TEST = 4'h8,
    FPXU_OP_LOAD = 4'h9,
    FPXU_OP_REAL_STORE = 4'hA,
    FPXU_OP_REAL_STORE_POP = 4'hB,
    FPXU_OP_INTEGER_STORE = 4'hC,
    FPXU_OP_INTEGER_STORE_POP = 4'hD,
    FPXU_OP_PACKED_DECIMAL_STORE_POP = 4'hE,
    FPXU_OP_REGISTER_EXCHANGE = 4'hF
  } fpxu_op_t;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    FPXU_ST_IDLE = 3'b001,
    FPXU_ST_FILL = 3'b010,
    FPXU_ST_XCHG = 3'b100
  } fpxu_state_t;

endpackage

// File: inc/fpxu_regs.svh
`ifndef FPXU_REGS_SVH
`define FPXU_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define FPXU_ADDR_CTRL 12'h000
`define FPXU_ADDR_STAT 12'h004
`define FPXU_CTRL_RESET 32'h0000003F
`define FPXU_CTRL_WMASK 32'h00001C3F

// ****************************************************************
// field positions
// ****************************************************************
`define FPXU_F_INVAL 0
`define FPXU_F_DENORM 1
`define FPXU_F_ZDIV 2
`define FPXU_F_OVF 3
`define FPXU_F_UNF 4
`define FPXU_F_PREC 5
`define FPXU_NCLASS 6
`define FPXU_RC_LO 10
`define FPXU_RC_HI 11
`define FPXU_AFFINE_BIT 12
`define FPXU_STAT_ES 7
`define FPXU_STAT_C0 8
`define FPXU_STAT_C1 9
`define FPXU_STAT_C2 10
`define FPXU_STAT_C3 14
`define FPXU_RC_NEAR 2'h0
`define FPXU_RC_CHOP 2'h3

// ****************************************************************
// temporary real layout and special values
// ****************************************************************
`define FPXU_SIGN_BIT 79
`define FPXU_EXP_HI 78
`define FPXU_EXP_LO 64
`define FPXU_INT_BIT 63
`define FPXU_FRAC_HI 62
`define FPXU_EXP_ONES 15'h7FFF
`define FPXU_EXP_ZERO 15'h0000
`define FPXU_REAL_INDEF 80'hFFFFC000000000000000
`define FPXU_SIG_INF 64'h8000000000000000
`define FPXU_INT_INDEF 80'h00008000000000000000
`define FPXU_BCD_INDEF 80'hFFFF0000000000000000
`define FPXU_EXP_OVF 18'sh03FFF
`define FPXU_EXP_UNF 18'sh3C002
// condition codes as {c3, c2, c1, c0}
`define FPXU_CC_UNORD 4'hD
`define FPXU_CC_REM_DONE 4'h0

`endif

// File: logic/fpxu_classify.sv
`include "fpxu_regs.svh"

module fpxu_classify (
  // operand and its tag
  input wire logic [79:0] value,
  input wire logic empty,
  // operand class
  output logic is_empty,
  output logic is_nan,
  output logic is_inf,
  output logic is_zero,
  output logic is_denorm,
  output logic is_unnorm,
  output logic is_pzero,
  output logic is_sign
);
  import fpxu_pkg::*;

  logic exp_max;
  logic exp_zero;
  logic int_bit;
  logic frac_zero;

  // field decode of the temporary real operand
  assign exp_max = value[`FPXU_EXP_HI:`FPXU_EXP_LO] == `FPXU_EXP_ONES;
  assign exp_zero = value[`FPXU_EXP_HI:`FPXU_EXP_LO] == `FPXU_EXP_ZERO;
  assign int_bit = value[`FPXU_INT_BIT];
  assign frac_zero = value[`FPXU_FRAC_HI:0] == '0;

  // an empty tag hides every other class except the sign
  assign is_empty = empty;
  assign is_nan = ~empty & exp_max & ~frac_zero;
  assign is_inf = ~empty & exp_max & frac_zero;
  assign is_zero = ~empty & exp_zero & ~int_bit & frac_zero;
  assign is_denorm = ~empty & exp_zero & ~(~int_bit & frac_zero);
  assign is_unnorm = ~empty & ~exp_zero & ~exp_max & ~int_bit;
  assign is_pzero = is_unnorm & frac_zero;
  assign is_sign = value[`FPXU_SIGN_BIT];

endmodule // fpxu_classify

// File: logic/fpxu_exception_unit.sv
// Functional notes
// - detect invalid, zero divide, denormal, overflow, underflow and precision classes
// - loading into a non-empty register is an invalid operation
// - reading an empty source register is an invalid operation
// - nan operands or indeterminate operations raise invalid operation
// - finite nonzero dividend over zero divisor raises zero divide
// - any denormal operand of a numeric operation raises denormal
// - exponent too large means overflow, too small means underflow
// - result not exact after rounding raises precision
// - every detected class sets its status flag before masking
// - masked class gives the default standard result and continues
// - unmasked class asserts the error output toward the host
// - masked empty source returns real indefinite
// - masked full destination is overwritten with real indefinite; for a nan load the code writes the loaded nan there instead
// - masked nan operands return the nan of larger magnitude
// - masked compare or test with nan sets not comparable codes
// - bad infinity sums and infinity times zero give real indefinite
// - bad divisions give real indefinite when masked
// - bad partial remainder gives indefinite and complete remainder code
// - bad square root operands give real indefinite when masked
// - bad integer store writes integer indefinite when masked
// - bad packed decimal store writes packed decimal indefinite
// - exchange fills empty registers with indefinite, then exchanges
// - masked overflow under nearest or chop gives signed infinity plus precision
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "fpxu_regs.svh"

module fpxu_exception_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operation request from the datapath
  input wire logic op_valid,
  output logic op_ready,
  input fpxu_pkg::fpxu_op_t op_code,
  input wire logic [79:0] opnd_a,
  input wire logic [79:0] opnd_b,
  input wire logic opnd_a_empty,
  input wire logic opnd_b_empty,
  input wire logic dest_full,
  // datapath result facts
  input wire logic [79:0] dp_result,
  input wire logic dp_sign,
  input wire logic signed [17:0] dp_exp,
  input wire logic dp_inexact,
  input wire logic dp_int_range_err,
  input wire logic dp_bcd_range_err,
  // response to the datapath
  output logic resp_valid,
  output logic resp_trap,
  output logic resp_default,
  output logic resp_write_dest,
  output logic [79:0] resp_result,
  output logic resp_cc_valid,
  output logic [3:0] resp_cc,
  output logic fill_a,
  output logic fill_b,
  output logic exch_go,
  // error toward the host
  output logic error_n
);
  import fpxu_pkg::*;

  // ****************************************************************
  // operand classification
  // ****************************************************************
  logic [1:0][79:0] opnd;
  logic [1:0] opnd_empty;
  logic [1:0] c_empty;
  logic [1:0] c_nan;
  logic [1:0] c_inf;
  logic [1:0] c_zero;
  logic [1:0] c_den;
  logic [1:0] c_unn;
  logic [1:0] c_pz;
  logic [1:0] c_sign;

  assign opnd = {opnd_b, opnd_a};
  assign opnd_empty = {opnd_b_empty, opnd_a_empty};

  // one classifier per operand
  for (genvar gi = 0; gi < 2; gi++) begin : g_cls
    fpxu_classify u_cls (
      .value(opnd[gi]),
      .empty(opnd_empty[gi]),
      .is_empty(c_empty[gi]),
      .is_nan(c_nan[gi]),
      .is_inf(c_inf[gi]),
      .is_zero(c_zero[gi]),
      .is_denorm(c_den[gi]),
      .is_unnorm(c_unn[gi]),
      .is_pzero(c_pz[gi]),
      .is_sign(c_sign[gi])
    );
  end

  // ****************************************************************
  // registers and sequencer state
  // ****************************************************************
  logic [31:0] ctrl_q;
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic [3:0] cc_q;
  logic error_q;
  fpxu_state_t state_q;
  logic [5:0] mask;
  logic affine;
  logic [1:0] rc;

  assign mask = ctrl_q[`FPXU_NCLASS-1:0];
  assign affine = ctrl_q[`FPXU_AFFINE_BIT];
  assign rc = ctrl_q[`FPXU_RC_HI:`FPXU_RC_LO];
  assign op_ready = state_q == FPXU_ST_IDLE;

  // ****************************************************************
  // exception detection
  // ****************************************************************
  logic fire;
  logic is_add;
  logic is_sub;
  logic is_mul;
  logic is_div;
  logic is_rem;
  logic is_sqrt;
  logic is_cmp;
  logic is_tst;
  logic is_ld;
  logic is_rst;
  logic is_ist;
  logic is_bst;
  logic is_xch;
  logic two_src;
  logic is_arith;
  logic uses_a;
  logic any_nan;
  logic both_inf;
  logic store_bad;
  logic inv_empty;
  logic inv_full;
  logic inv_nan;
  logic inv_add;
  logic inv_mul;
  logic inv_div;
  logic inv_rem;
  logic inv_sqrt;
  logic inv_cmp;
  logic inv_ist;
  logic inv_bst;
  logic inv_rst;
  logic ovf_big;
  logic ovf_inf;
  logic [5:0] exc;

  assign fire = op_valid & op_ready;
  assign is_add = op_code == FPXU_OP_ADD;
  assign is_sub = op_code == FPXU_OP_SUB;
  assign is_mul = op_code == FPXU_OP_MUL;
  assign is_div = op_code == FPXU_OP_DIV;
  assign is_rem = op_code == FPXU_OP_PARTIAL_REMAINDER;
  assign is_sqrt = op_code == FPXU_OP_SQUARE_ROOT;
  assign is_cmp = op_code == FPXU_OP_COMPARE;
  assign is_tst = op_code == FPXU_OP_ZERO_TEST;
  assign is_ld = op_code == FPXU_OP_LOAD;
  assign is_rst = op_code == FPXU_OP_REAL_STORE || op_code == FPXU_OP_REAL_STORE_POP;
  assign is_ist = op_code == FPXU_OP_INTEGER_STORE || op_code == FPXU_OP_INTEGER_STORE_POP;
  assign is_bst = op_code == FPXU_OP_PACKED_DECIMAL_STORE_POP;
  assign is_xch = op_code == FPXU_OP_REGISTER_EXCHANGE;
  assign two_src = is_add | is_sub | is_mul | is_div | is_rem | is_cmp;
  assign is_arith = is_add | is_sub | is_mul | is_div | is_rem | is_sqrt;
  // load takes operand a from memory, so it never reads an empty register
  assign uses_a = two_src | is_sqrt | is_tst | is_rst | is_ist | is_bst;

  // stack faults
  assign inv_empty = (uses_a & c_empty[0]) | (two_src & c_empty[1]) | (is_xch & |c_empty);
  assign inv_full = is_ld & dest_full;

  // nan and indeterminate forms
  assign any_nan = (uses_a | is_ld) & c_nan[0] | two_src & c_nan[1];
  assign inv_nan = any_nan;
  assign both_inf = c_inf[0] & c_inf[1];
  assign inv_add = both_inf & (~affine | (is_add & (c_sign[0] ^ c_sign[1]))
                   | (is_sub & ~(c_sign[0] ^ c_sign[1]))) & (is_add | is_sub);
  assign inv_mul = is_mul & ((c_inf[0] & c_zero[1]) | (c_zero[0] & c_inf[1]));
  assign inv_div = is_div & (both_inf | (c_zero[0] & (c_zero[1] | c_pz[1]))
                   | c_den[1] | c_unn[1]);
  assign inv_rem = is_rem & (c_unn[1] | c_den[1] | c_inf[0]);
  assign inv_sqrt = is_sqrt & ((c_sign[0] & ~c_zero[0] & ~c_nan[0]) | c_den[0] | c_unn[0]
                    | (c_inf[0] & (~affine | c_sign[0])));
  assign inv_cmp = ~affine & ((is_cmp & ((c_inf[0] & ~c_nan[1] & ~c_den[1] & ~c_unn[1])
                   | (c_inf[1] & ~c_nan[0] & ~c_den[0] & ~c_unn[0]))) | (is_tst & c_inf[0]));
  assign store_bad = c_empty[0] | c_nan[0] | c_den[0] | c_unn[0] | c_inf[0];
  assign inv_ist = is_ist & (store_bad | dp_int_range_err);
  assign inv_bst = is_bst & (store_bad | dp_bcd_range_err);
  assign inv_rst = is_rst & c_unn[0] & ~c_pz[0];

  // masked overflow under nearest or chop turns into a signed infinity and an inexact result
  assign ovf_big = is_arith & (dp_exp > `FPXU_EXP_OVF);
  assign ovf_inf = ovf_big & mask[`FPXU_F_OVF] & (rc == `FPXU_RC_NEAR || rc == `FPXU_RC_CHOP);

  // per class detection, all six classes
  always_comb begin
    exc = '0;
    exc[`FPXU_F_INVAL] = inv_empty | inv_full | inv_nan | inv_add | inv_mul | inv_div
                         | inv_rem | inv_sqrt | inv_cmp | inv_ist | inv_bst | inv_rst;
    exc[`FPXU_F_ZDIV] = is_div & c_zero[1] & ~c_zero[0] & ~c_inf[0] & ~c_nan[0]
                        & ~c_empty[0] & ~c_empty[1];
    exc[`FPXU_F_DENORM] = (is_arith | is_cmp | is_tst | is_ld) & ((uses_a | is_ld) & c_den[0]
                          | two_src & c_den[1]);
    exc[`FPXU_F_OVF] = ovf_big;
    exc[`FPXU_F_UNF] = is_arith & (dp_exp < `FPXU_EXP_UNF);
    exc[`FPXU_F_PREC] = (is_arith | is_rst | is_ist | is_bst) & dp_inexact | ovf_inf;
  end

  // ****************************************************************
  // masked responses
  // ****************************************************************
  logic [79:0] res_d;
  logic dflt_d;
  logic wdest_d;
  logic ccv_d;
  logic [3:0] cc_d;
  logic trap_d;
  logic need_fill;
  logic big_b;

  assign trap_d = |(exc & ~mask);
  assign need_fill = is_xch & |c_empty & mask[`FPXU_F_INVAL];
  // magnitude compare ignores the sign bits
  assign big_b = ~c_nan[0] | (two_src & c_nan[1] & (opnd_b[`FPXU_EXP_HI:0] > opnd_a[`FPXU_EXP_HI:0]));

  // default value selection, invalid first since it stops the rest
  always_comb begin
    res_d = dp_result;
    dflt_d = 1'b0;
    wdest_d = 1'b0;
    ccv_d = 1'b0;
    cc_d = cc_q;
    if (exc[`FPXU_F_INVAL] & mask[`FPXU_F_INVAL]) begin
      dflt_d = 1'b1;
      res_d = `FPXU_REAL_INDEF;
      if (inv_full) begin
        wdest_d = 1'b1;
      end
      if (is_cmp | is_tst) begin
        ccv_d = 1'b1;
        cc_d = `FPXU_CC_UNORD;
      end else if (inv_ist) begin
        res_d = `FPXU_INT_INDEF;
      end else if (inv_bst) begin
        res_d = `FPXU_BCD_INDEF;
      end else if (inv_rem) begin
        ccv_d = 1'b1;
        cc_d = `FPXU_CC_REM_DONE;
      end else if (any_nan & ~inv_empty) begin
        res_d = big_b ? opnd_b : opnd_a;
      end
    end else if (exc[`FPXU_F_ZDIV] & mask[`FPXU_F_ZDIV]) begin
      dflt_d = 1'b1;
      res_d = {c_sign[0] ^ c_sign[1], `FPXU_EXP_ONES, `FPXU_SIG_INF};
    end else if (ovf_inf) begin
      dflt_d = 1'b1;
      res_d = {dp_sign, `FPXU_EXP_ONES, `FPXU_SIG_INF};
    end
  end

  // ****************************************************************
  // status flags, condition codes and error
  // ****************************************************************
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_stat;
  logic [5:0] w1c;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign hit_ctrl = paddr == `FPXU_ADDR_CTRL;
  assign hit_stat = paddr == `FPXU_ADDR_STAT;
  assign w1c = (wr_en & hit_stat & pstrb[0]) ? pwdata[`FPXU_NCLASS-1:0] : 6'h00;

  // a new event beats a same-cycle clear
  assign flags_d = (flags_q & ~w1c) | (fire ? exc : 6'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // error follows any set flag whose mask is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_q <= 1'b0;
    end else begin
      error_q <= |(flags_d & ~mask);
    end
  end

  assign error_n = ~error_q;

  // condition codes are held for status reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_q <= '0;
    end else if (fire & ccv_d) begin
      cc_q <= cc_d;
    end
  end

  // control word with byte lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `FPXU_CTRL_RESET;
    end else if (wr_en & hit_ctrl) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          ctrl_q[i*8 +: 8] <= pwdata[i*8 +: 8] & 8'(`FPXU_CTRL_WMASK >> (i*8));
        end
      end
    end
  end

  // ****************************************************************
  // apb read path
  // ****************************************************************
  logic [31:0] stat_word;

  always_comb begin
    stat_word = '0;
    stat_word[`FPXU_NCLASS-1:0] = flags_q;
    stat_word[`FPXU_STAT_ES] = error_q;
    stat_word[`FPXU_STAT_C0] = cc_q[0];
    stat_word[`FPXU_STAT_C1] = cc_q[1];
    stat_word[`FPXU_STAT_C2] = cc_q[2];
    stat_word[`FPXU_STAT_C3] = cc_q[3];
  end

  // read data captured in the setup cycle so the access cycle needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      prdata <= hit_ctrl ? ctrl_q : (hit_stat ? stat_word : 32'h00000000);
    end
  end

  // unmapped address answers with an error, writes there are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pslverr <= ~(hit_ctrl | hit_stat);
    end
  end

  assign pready = 1'b1;

  // ****************************************************************
  // response registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid <= 1'b0;
      resp_trap <= 1'b0;
      resp_default <= 1'b0;
      resp_write_dest <= 1'b0;
      resp_cc_valid <= 1'b0;
    end else begin
      resp_valid <= fire;
      resp_trap <= fire & trap_d;
      resp_default <= fire & dflt_d & ~trap_d;
      resp_write_dest <= fire & wdest_d & ~trap_d;
      resp_cc_valid <= fire & ccv_d & ~trap_d;
    end
  end

  // data fields load only with a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_result <= '0;
      resp_cc <= '0;
    end else if (fire) begin
      resp_result <= res_d;
      resp_cc <= cc_d;
    end
  end

  // ****************************************************************
  // exchange sequencer
  // ****************************************************************
  // fill goes out one cycle ahead of the swap so the register file sees indefinite first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FPXU_ST_IDLE;
      fill_a <= 1'b0;
      fill_b <= 1'b0;
      exch_go <= 1'b0;
    end else begin
      fill_a <= 1'b0;
      fill_b <= 1'b0;
      exch_go <= 1'b0;
      unique case (state_q)
        FPXU_ST_IDLE: begin
          if (fire & is_xch & ~trap_d) begin
            if (need_fill) begin
              state_q <= FPXU_ST_FILL;
              fill_a <= c_empty[0];
              fill_b <= c_empty[1];
            end else begin
              exch_go <= 1'b1;
            end
          end
        end
        FPXU_ST_FILL: begin
          state_q <= FPXU_ST_XCHG;
          exch_go <= 1'b1;
        end
        FPXU_ST_XCHG: begin
          state_q <= FPXU_ST_IDLE;
        end
      endcase
    end
  end

endmodule // fpxu_exception_unit

// File: tb/fpxu_exception_unit_bench.sv
`include "fpxu_regs.svh"
module fpxu_exception_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fpxu_pkg::*;
  localparam logic [79:0] ONE = 80'h3FFF8000000000000000;
  localparam logic [79:0] PINF = 80'h7FFF8000000000000000;
  localparam logic [79:0] QNAN = 80'h7FFFC000000000000000;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, op_valid = 0, op_ready, ae = 0, be = 0, dest_full = 0, dp_sign = 0, dp_inexact = 0;
  fpxu_op_t op_code = FPXU_OP_NONE;
  logic [79:0] opnd_a = 0, opnd_b = 0, dp_result = 0, resp_result;
  logic signed [17:0] dp_exp = 0;
  logic resp_valid, resp_trap, resp_default, resp_write_dest, resp_cc_valid, fill_a, fill_b, exch_go, error_n, se;
  logic [3:0] resp_cc;
  int err_count = 0, compares = 0, cyc = 0, calls;
  always #25 pclk = ~pclk;
  fpxu_exception_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .opnd_a(opnd_a), .opnd_b(opnd_b),
    .opnd_a_empty(ae), .opnd_b_empty(be), .dest_full(dest_full), .dp_result(dp_result), .dp_sign(dp_sign),
    .dp_exp(dp_exp), .dp_inexact(dp_inexact), .dp_int_range_err(1'b0), .dp_bcd_range_err(1'b0),
    .resp_valid(resp_valid), .resp_trap(resp_trap), .resp_default(resp_default), .resp_write_dest(resp_write_dest),
    .resp_result(resp_result), .resp_cc_valid(resp_cc_valid), .resp_cc(resp_cc), .fill_a(fill_a),
    .fill_b(fill_b), .exch_go(exch_go), .error_n(error_n));
  fpxu_host_model host (.pclk(pclk), .presetn(presetn), .error_n(error_n), .handler_calls(calls));
  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; se = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // one operation; returns at mid-cycle of the response
  task automatic op(input fpxu_op_t c, input logic [79:0] a, input logic [79:0] b, input logic xa,
    input logic signed [17:0] x);
    @(posedge pclk);
    op_code <= c; opnd_a <= a; opnd_b <= b; ae <= xa; dp_exp <= x; op_valid <= 1;
    do @(negedge pclk); while (op_ready !== 1'b1);
    @(posedge pclk);
    op_valid <= 0;
    @(negedge pclk);
    chk("resp_valid", resp_valid, 1);
  endtask
  // read flags, compare, then clear them by write-one
  task automatic flags(input logic [5:0] e);
    apb(0, `FPXU_ADDR_STAT, 0);
    chk("flags", rd[5:0], e);
    apb(1, `FPXU_ADDR_STAT, 32'h0000003F);
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_regs();
    apb(0, `FPXU_ADDR_CTRL, 0);
    chk("ctrl reset", rd, 32'h0000003F);
    apb(0, 12'h010, 0);
    chk("slverr", se, 1);
  endtask
  task automatic t_masked();
    op(FPXU_OP_ADD, ONE, ONE, 1, 0);
    chk("empty src", resp_result, `FPXU_REAL_INDEF);
    chk("default", resp_default, 1);
    flags(6'h01);
    op(FPXU_OP_DIV, ONE, 80'h0, 0, 0);
    chk("zero divide", resp_result, PINF);
    flags(6'h04);
    op(FPXU_OP_COMPARE, QNAN, ONE, 0, 0);
    chk("nan cc", {resp_cc_valid, resp_cc}, 5'h1D);
    flags(6'h01);
    op(FPXU_OP_MUL, ONE, ONE, 0, 18'sd16384);
    chk("overflow", resp_result, PINF);
    flags(6'h28);
  endtask
  // exchange with one empty register fills it first
  task automatic t_exchange();
    op(FPXU_OP_REGISTER_EXCHANGE, ONE, ONE, 1, 0);
    chk("fill", {fill_a, fill_b, exch_go}, 3'b100);
    @(negedge pclk);
    chk("swap", exch_go, 1);
    flags(6'h01);
  endtask
  // unmasked invalid traps to the host, clearing the flag releases it
  task automatic t_trap();
    apb(1, `FPXU_ADDR_CTRL, 32'h0000003E);
    op(FPXU_OP_ADD, ONE, ONE, 1, 0);
    chk("trap", {resp_trap, resp_default, error_n}, 3'b100);
    flags(6'h01);
    @(negedge pclk);
    chk("error released", error_n, 1);
    chk("handler calls", calls, 1);
    apb(1, `FPXU_ADDR_CTRL, 32'h0000003F);
  endtask
  // full destination, denormal, nan choice, indeterminate forms and stores, all masked
  task automatic t_more();
    @(posedge pclk);
    dest_full <= 1;
    op(FPXU_OP_LOAD, ONE, ONE, 0, 0);
    chk("write dest", resp_write_dest, 1);
    flags(6'h01);
    dest_full <= 0;
    dp_inexact <= 1;
    op(FPXU_OP_SUB, PINF, PINF, 0, 0);
    chk("inf minus inf", resp_result, `FPXU_REAL_INDEF);
    flags(6'h21);
    dp_inexact <= 0;
    op(FPXU_OP_ADD, 80'h1, ONE, 0, 0);
    flags(6'h02);
    op(FPXU_OP_ADD, QNAN, 80'hFFFFE000000000000000, 0, 0);
    chk("larger nan", resp_result, 80'hFFFFE000000000000000);
    op(FPXU_OP_DIV, PINF, PINF, 0, 0);
    chk("inf over inf", resp_result, `FPXU_REAL_INDEF);
    op(FPXU_OP_PARTIAL_REMAINDER, PINF, ONE, 0, 0);
    chk("remainder cc", {resp_cc_valid, resp_cc}, 5'h10);
    op(FPXU_OP_SQUARE_ROOT, 80'hBFFF8000000000000000, ONE, 0, 0);
    chk("negative root", resp_result, `FPXU_REAL_INDEF);
    op(FPXU_OP_INTEGER_STORE, QNAN, ONE, 0, 0);
    chk("integer store", resp_result, `FPXU_INT_INDEF);
    op(FPXU_OP_PACKED_DECIMAL_STORE_POP, PINF, ONE, 0, 0);
    chk("decimal store", resp_result, `FPXU_BCD_INDEF);
    flags(6'h01);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_masked();
    t_exchange();
    t_trap();
    t_more();
    close_out();
  end
endmodule // fpxu_exception_unit_bench
bind fpxu_exception_unit fpxu_exception_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .op_valid(op_valid), .op_ready(op_ready),
  .resp_valid(resp_valid), .resp_trap(resp_trap), .resp_default(resp_default), .fill_a(fill_a),
  .fill_b(fill_b), .exch_go(exch_go), .error_n(error_n));

// File: tb/fpxu_exception_unit_properties.sv
// ************************************************
// exception unit port checker
// ************************************************
module fpxu_exception_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  // operation side
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic resp_valid,
  input wire logic resp_trap,
  input wire logic resp_default,
  input wire logic fill_a,
  input wire logic fill_b,
  input wire logic exch_go,
  input wire logic error_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // response timing tied to the accept edge
  a_resp_after_accept: assert property (op_valid && op_ready |=> resp_valid)
    else $error("no response one cycle after accept");
  a_no_stray_resp: assert property (!(op_valid && op_ready) |=> !resp_valid)
    else $error("response without accept");
  // exchange fill sequence holds off new requests for two cycles
  a_fill_holds_ready: assert property ((fill_a || fill_b) |-> !op_ready ##1 !op_ready ##1 op_ready)
    else $error("ready wrong around filling exchange");
  a_fill_then_swap: assert property ((fill_a || fill_b) |=> exch_go)
    else $error("exchange not started after fill");
  // unmasked path raises error and gives no default or fill, a default only comes with a response, unmapped access gets pslverr
  a_trap_error_low: assert property (resp_trap |-> !error_n)
    else $error("trap without error output");
  a_trap_no_default: assert property (resp_trap |-> !resp_default && !fill_a && !fill_b)
    else $error("default given on trap");
  a_default_in_resp: assert property (resp_default |-> resp_valid)
    else $error("default outside response");
  a_unmapped_slverr: assert property (psel && penable && paddr != 12'h000 && paddr != 12'h004 |-> pslverr)
    else $error("unmapped access not refused");
  // main scenarios
  c_trap: cover property (resp_trap);
  c_fill: cover property (fill_a ##1 exch_go);
  c_default: cover property (resp_default);
endmodule // fpxu_exception_checker

// File: tb/fpxu_host_model.sv
// ************************************************
// host cpu: counts handler entries on error
// ************************************************
module fpxu_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // error from the coprocessor
  input wire logic error_n,
  output int handler_calls
);
  timeunit 1ns;
  timeprecision 1ps;
  logic err_seen_q;
  // a level error enters the handler once per assertion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_seen_q <= 1'b0;
      handler_calls <= 0;
    end else begin
      err_seen_q <= !error_n;
      if (!error_n && !err_seen_q) handler_calls <= handler_calls + 1;
    end
  end
endmodule // fpxu_host_model
